// ---- hdl/watchdog_timer.sv ----
/*
  Watchdog timer with selectable timeout action (processor reset or interrupt),
  reached over APB. Assumes the bus master runs on clk_sys and that the
  processor reset controller consumes the one-cycle reset request.
*/
// Overview of operation
// RULE1: The watchdog stays idle until software sets the power-on bit.
// RULE2: The expiry interval comes from the five-bit expiry count field of the control register.
// RULE3: Arm, disarm and restart act only on a write of 1 followed by a write of 0 to the bit.
// RULE4: Completing the arm sequence with power on starts the countdown.
// RULE5: Completing the disarm sequence stops the watchdog and clears the arm status.
// RULE6: Software must restart or disarm before expiry or the timeout action happens.
// RULE7: The power-on bit alone never enables the reset; only the reset-enable bit does.
// RULE8: With reset enabled a timeout requests a processor reset and never raises the interrupt.
// RULE9: The reset-enable bit comes out of reset set.
// RULE10: Flash configuration zero is reached only through the flash address and data registers.
// RULE11: Software clears reset-enable and enables the interrupt to service timeouts by interrupt.
// RULE12: With reset disabled the timeout interrupt vectors to 0x0063.
// RULE13: Disarm is the 0x40 bit of the control register.
// RULE14: Restart is the 0x20 bit of the control register.
// RULE15: Power-on is the 0x04 bit of the power-management register.
// RULE16: A timeout without reset sets a sticky flag and interrupts when enabled; restart reloads.
`timescale 1ns/1ps

module watchdog_timer #(
  parameter int TICK_CYCLES = watchdog_pkg::TICK_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire watchdog_pkg::apb_req_s apb_req,
  output      watchdog_pkg::apb_rsp_s apb_rsp,
  output      logic                   wd_reset_req,
  output      logic                   wd_irq,
  output      logic [15:0]            wd_irq_vector,
  output      logic                   wd_running
);

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  function automatic logic completes(input logic prev, input logic now_bit);
    completes = prev & ~now_bit;
  endfunction

  function automatic logic is_mapped(input logic [watchdog_pkg::ADDR_W-1:0] a);
    is_mapped = (a == watchdog_pkg::OFS_POWER_MGMT) || (a == watchdog_pkg::OFS_WD_CONTROL) ||
                (a == watchdog_pkg::OFS_FLASH_ADDR) || (a == watchdog_pkg::OFS_FLASH_DATA) ||
                (a == watchdog_pkg::OFS_IRQ_STATUS) || (a == watchdog_pkg::OFS_IRQ_MASK);
  endfunction

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  watchdog_pkg::wd_state_s q;
  watchdog_pkg::wd_state_s n;

  logic       wr_commit;
  logic       rd_phase;
  logic       wr_ctl;
  logic       arm_evt;
  logic       disarm_evt;
  logic       restart_evt;
  logic       timeout;
  logic [2:0] ctl_now;

  // ==========================================================================
  // Bus decode and control sequences.
  // ==========================================================================
  // The bus answers with one wait state; a write lands on the edge that samples pready.
  assign wr_commit = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite;
  assign rd_phase  = apb_req.psel & apb_req.penable & ~q.rsp.pready;
  assign wr_ctl    = wr_commit & (apb_req.paddr == watchdog_pkg::OFS_WD_CONTROL);
  assign ctl_now   = {apb_req.pwdata[watchdog_pkg::ARM_BIT],
                      apb_req.pwdata[watchdog_pkg::DISARM_BIT], // RULE13
                      apb_req.pwdata[watchdog_pkg::RESTART_BIT]}; // RULE14

  // A sequence completes on the write of 0 that follows a write of 1.
  assign arm_evt     = wr_ctl & completes(q.ctl_prev[2], ctl_now[2]) & q.power_on; // RULE3
  assign disarm_evt  = wr_ctl & completes(q.ctl_prev[1], ctl_now[1]); // RULE3
  assign restart_evt = wr_ctl & completes(q.ctl_prev[0], ctl_now[0]); // RULE3

  assign timeout = (q.state == watchdog_pkg::WD_RUN) && (q.tick_cnt == 32'h0000_0000) &&
                   (q.unit_cnt == '0); // RULE6

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    n                = q;
    n.rsp.pready     = 1'b0;
    n.rsp.pslverr    = 1'b0;
    n.reset_req      = 1'b0;

    if (rd_phase) begin
      n.rsp.pready  = 1'b1;
      n.rsp.pslverr = ~is_mapped(apb_req.paddr);
      n.rsp.prdata  = 32'h0000_0000;
      case (apb_req.paddr)
        watchdog_pkg::OFS_POWER_MGMT: begin
          n.rsp.prdata[watchdog_pkg::POWER_ON_BIT] = q.power_on;
        end
        watchdog_pkg::OFS_WD_CONTROL: begin
          n.rsp.prdata[watchdog_pkg::ARM_BIT]             = (q.state == watchdog_pkg::WD_RUN);
          n.rsp.prdata[watchdog_pkg::EXPIRY_W-1:0]        = q.expiry;
        end
        watchdog_pkg::OFS_FLASH_ADDR: begin
          n.rsp.prdata[7:0] = q.flash_addr;
        end
        watchdog_pkg::OFS_FLASH_DATA: begin
          if (q.flash_addr == watchdog_pkg::FLASH_CFG0_ADDR) begin
            n.rsp.prdata[7:0] = q.flash_cfg0; // RULE10
          end
        end
        watchdog_pkg::OFS_IRQ_STATUS: begin
          n.rsp.prdata[0] = q.irq_sts;
        end
        watchdog_pkg::OFS_IRQ_MASK: begin
          n.rsp.prdata[0] = q.irq_msk;
        end
        default: begin
          n.rsp.prdata = 32'h0000_0000;
        end
      endcase
    end

    if (wr_commit) begin
      case (apb_req.paddr)
        watchdog_pkg::OFS_POWER_MGMT: begin
          n.power_on = apb_req.pwdata[watchdog_pkg::POWER_ON_BIT]; // RULE15
        end
        watchdog_pkg::OFS_WD_CONTROL: begin
          n.expiry   = apb_req.pwdata[watchdog_pkg::EXPIRY_W-1:0]; // RULE2
          n.ctl_prev = ctl_now;
        end
        watchdog_pkg::OFS_FLASH_ADDR: begin
          n.flash_addr = apb_req.pwdata[7:0];
        end
        watchdog_pkg::OFS_FLASH_DATA: begin
          if (q.flash_addr == watchdog_pkg::FLASH_CFG0_ADDR) begin
            n.flash_cfg0 = apb_req.pwdata[7:0]; // RULE10
          end
        end
        watchdog_pkg::OFS_IRQ_STATUS: begin
          if (apb_req.pwdata[0]) begin
            n.irq_sts = 1'b0;
          end
        end
        watchdog_pkg::OFS_IRQ_MASK: begin
          n.irq_msk = apb_req.pwdata[0];
        end
        default: begin
          n.irq_msk = q.irq_msk;
        end
      endcase
    end

    case (q.state)
      watchdog_pkg::WD_IDLE: begin
        if (arm_evt && !disarm_evt) begin
          n.state    = watchdog_pkg::WD_RUN; // RULE4
          n.unit_cnt = n.expiry; // RULE2
          n.tick_cnt = TICK_LAST;
        end
      end
      watchdog_pkg::WD_RUN: begin
        if (q.tick_cnt != 32'h0000_0000) begin
          n.tick_cnt = q.tick_cnt - 32'h0000_0001;
        end else if (q.unit_cnt != '0) begin
          n.tick_cnt = TICK_LAST;
          n.unit_cnt = q.unit_cnt - 1'b1;
        end
        if (timeout) begin
          n.tick_cnt = TICK_LAST;
          n.unit_cnt = q.expiry;
          if (q.flash_cfg0[watchdog_pkg::RESET_EN_BIT]) begin // RULE7
            n.reset_req = 1'b1; // RULE8
            n.state     = watchdog_pkg::WD_IDLE;
          end else begin
            n.irq_sts = 1'b1; // RULE16
          end
        end
        if (restart_evt) begin
          n.unit_cnt = n.expiry; // RULE16
          n.tick_cnt = TICK_LAST;
        end
        if (disarm_evt || !q.power_on) begin
          n.state = watchdog_pkg::WD_IDLE; // RULE5
        end
      end
      default: begin
        n.state = watchdog_pkg::WD_IDLE;
      end
    endcase

    // The power-on bit stops a running watchdog but never touches the reset enable.
    if (!n.power_on) begin
      n.state = watchdog_pkg::WD_IDLE; // RULE1
    end

    n.irq = n.irq_sts & n.irq_msk; // RULE16
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q            <= '0;
      q.state      <= watchdog_pkg::WD_IDLE;
      q.flash_cfg0 <= watchdog_pkg::FLASH_CFG0_RST; // RULE9
      q.vector     <= watchdog_pkg::TIMEOUT_VECTOR; // RULE12
    end else begin
      q <= n;
    end
  end

  assign apb_rsp       = q.rsp;
  assign wd_reset_req  = q.reset_req;
  assign wd_irq        = q.irq;
  assign wd_irq_vector = q.vector;
  assign wd_running    = (q.state == watchdog_pkg::WD_RUN);

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  AST_IDLE_UNTIL_POWER: // RULE1
    assert property (!q.power_on |=> q.state == watchdog_pkg::WD_IDLE)
    else $error("Watchdog runs while powered off.");

  AST_ARM_STARTS_COUNT: // RULE4
    assert property ((q.state == watchdog_pkg::WD_IDLE) && arm_evt && !disarm_evt && q.power_on
                     |=> wd_running && (q.unit_cnt == $past(n.expiry)))
    else $error("Arm sequence did not start the countdown.");

  AST_SINGLE_WRITE_NO_ARM: // RULE3
    assert property ((q.state == watchdog_pkg::WD_IDLE) && wr_ctl && !q.ctl_prev[2]
                     |=> q.state == watchdog_pkg::WD_IDLE)
    else $error("Watchdog armed without a one-then-zero sequence.");

  AST_DISARM_STOPS: // RULE5
    assert property (wd_running && disarm_evt |=> !wd_running ##1 !wd_running)
    else $error("Disarm sequence did not stop the watchdog.");

  AST_RESET_NOT_IRQ: // RULE8
    assert property (timeout && q.flash_cfg0[watchdog_pkg::RESET_EN_BIT]
                     |=> q.reset_req && ($past(q.irq_sts) || !q.irq_sts))
    else $error("Timeout with reset enabled did not request reset alone.");

  AST_RESET_NEEDS_ENABLE: // RULE7
    assert property ($rose(q.reset_req) |-> $past(q.flash_cfg0[watchdog_pkg::RESET_EN_BIT]) && $past(timeout))
    else $error("Reset requested without reset enable.");

  AST_TIMEOUT_FLAG: // RULE16
    assert property (timeout && !q.flash_cfg0[watchdog_pkg::RESET_EN_BIT] |=> q.irq_sts && !q.reset_req)
    else $error("Timeout without reset did not set the flag.");

  AST_IRQ_FOLLOWS_MASK: // RULE16
    assert property (q.irq_sts && q.irq_msk |=> q.irq || $past(wr_commit))
    else $error("Unmasked flag did not raise the interrupt.");

  AST_VECTOR_FIXED: // RULE12
    assert property (wd_irq_vector == 16'h0063)
    else $error("Timeout vector is wrong.");

  AST_RESTART_RELOADS: // RULE2
    assert property (wd_running && restart_evt && !disarm_evt && q.power_on && !timeout
                     |=> q.unit_cnt == $past(n.expiry) && q.tick_cnt == TICK_LAST)
    else $error("Restart did not reload the countdown.");

  AST_EXPIRY_LOADS: // RULE2
    assert property (wr_ctl |=> q.expiry == $past(apb_req.pwdata[watchdog_pkg::EXPIRY_W-1:0]))
    else $error("Control write did not load the expiry count.");

  AST_UNIT_STEPS_DOWN: // RULE2
    assert property (wd_running && !restart_evt && (q.tick_cnt == 32'h0000_0000) && (q.unit_cnt != '0)
                     |=> (q.unit_cnt == $past(q.unit_cnt) - 5'h1) && (q.tick_cnt == TICK_LAST))
    else $error("Expiry unit did not step down.");

  AST_TICK_COUNTS_DOWN: // RULE3
    assert property (wd_running && !restart_evt && (q.tick_cnt != 32'h0000_0000)
                     |=> q.tick_cnt == $past(q.tick_cnt) - 32'h0000_0001)
    else $error("Countdown disturbed without a restart sequence.");

  AST_IDLE_NEEDS_ARM: // RULE4
    assert property (!wd_running && !arm_evt |=> !wd_running)
    else $error("Watchdog started without an arm sequence.");

  AST_DISARM_CLEARS_ARM: // RULE5
    assert property (disarm_evt |=> !wd_running)
    else $error("Disarm sequence left the watchdog armed.");

  AST_ARM_STATUS_READ: // RULE5
    assert property (apb_rsp.pready && !apb_req.pwrite && (apb_req.paddr == watchdog_pkg::OFS_WD_CONTROL)
                     |-> (apb_rsp.prdata[watchdog_pkg::ARM_BIT] == $past(wd_running)) &&
                         !apb_rsp.prdata[watchdog_pkg::DISARM_BIT] && !apb_rsp.prdata[watchdog_pkg::RESTART_BIT])
    else $error("Control read shows the wrong arm status.");

  AST_POWER_KEEPS_RESET_EN: // RULE7
    assert property ($changed(q.power_on) |-> $stable(q.flash_cfg0[watchdog_pkg::RESET_EN_BIT]))
    else $error("Power-on change altered the reset enable.");

  AST_RESET_ONE_CYCLE: // RULE8
    assert property (q.reset_req |=> !q.reset_req)
    else $error("Reset request lasted more than one cycle.");

  AST_RESET_STOPS_COUNT: // RULE8
    assert property (q.reset_req |-> !wd_running)
    else $error("Watchdog kept running after a reset request.");

  AST_NO_FLAG_WITH_RESET: // RULE8
    assert property (q.flash_cfg0[watchdog_pkg::RESET_EN_BIT] && !q.irq_sts |=> !q.irq_sts)
    else $error("Interrupt flag set while the reset is enabled.");

  AST_CFG0_UNTOUCHED: // RULE10
    assert property (wr_commit && (apb_req.paddr != watchdog_pkg::OFS_FLASH_DATA) |=> $stable(q.flash_cfg0))
    else $error("Flash configuration changed by another register.");

  AST_CFG0_THROUGH_DATA: // RULE10
    assert property (wr_commit && (apb_req.paddr == watchdog_pkg::OFS_FLASH_DATA) &&
                     (q.flash_addr == watchdog_pkg::FLASH_CFG0_ADDR)
                     |=> q.flash_cfg0 == $past(apb_req.pwdata[7:0]))
    else $error("Flash configuration write did not land.");

  AST_PREADY_ONE_CYCLE: // Bus ready lasts one cycle.
    assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("Bus ready lasted more than one cycle.");

  AST_POWER_OFF_STOPS: // RULE15
    assert property (wr_commit && (apb_req.paddr == watchdog_pkg::OFS_POWER_MGMT) &&
                     !apb_req.pwdata[watchdog_pkg::POWER_ON_BIT] |=> !wd_running)
    else $error("Clearing power-on did not stop the watchdog.");

  AST_IRQ_IS_STS_AND_MSK: // RULE16
    assert property (q.irq == (q.irq_sts && q.irq_msk))
    else $error("Interrupt differs from flag and mask.");

  AST_FLAG_STICKY: // RULE16
    assert property (q.irq_sts && !(wr_commit && (apb_req.paddr == watchdog_pkg::OFS_IRQ_STATUS)) |=> q.irq_sts)
    else $error("Interrupt flag dropped without a clear.");

  AST_FLAG_CLEARS: // RULE16
    assert property (wr_commit && (apb_req.paddr == watchdog_pkg::OFS_IRQ_STATUS) && apb_req.pwdata[0] && !timeout
                     |=> !q.irq_sts)
    else $error("Write of one did not clear the interrupt flag.");

  AST_IRQ_PATH_RELOADS: // RULE16
    assert property (timeout && !q.flash_cfg0[watchdog_pkg::RESET_EN_BIT] && !wr_commit
                     |=> wd_running && (q.unit_cnt == $past(q.expiry)))
    else $error("Interrupt timeout did not reload the countdown.");

endmodule

// ---- hdl/watchdog_pkg.sv ----
/*
  Constants, register map and carrier types for the watchdog block.
  Assumes an APB master with 32-bit data and byte addresses in paddr.
*/
package watchdog_pkg;

  // ==========================================================================
  // Register map.
  // ==========================================================================
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_POWER_MGMT  = 8'h00;
  localparam logic [7:0]  OFS_WD_CONTROL  = 8'h04;
  localparam logic [7:0]  OFS_FLASH_ADDR  = 8'h08;
  localparam logic [7:0]  OFS_FLASH_DATA  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h14;

  // ==========================================================================
  // Field positions and reset values.
  // ==========================================================================
  localparam int          POWER_ON_BIT    = 2;
  localparam int          ARM_BIT         = 7;
  localparam int          DISARM_BIT      = 6;
  localparam int          RESTART_BIT     = 5;
  localparam int          EXPIRY_W        = 5;
  localparam int          RESET_EN_BIT    = 3;
  localparam logic [7:0]  FLASH_CFG0_ADDR = 8'h7F;
  localparam logic [7:0]  FLASH_CFG0_RST  = 8'h08;
  localparam logic [15:0] TIMEOUT_VECTOR  = 16'h0063;

  // ==========================================================================
  // Timing: one expiry count unit lasts one tick.
  // ==========================================================================
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          TICK_TIME_US    = 1000;
  localparam int          TICK_CYCLES     = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic {
    WD_IDLE,
    WD_RUN
  } wd_state_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    wd_state_e           state;
    logic                power_on;
    logic [EXPIRY_W-1:0] expiry;
    logic [2:0]          ctl_prev;
    logic [7:0]          flash_addr;
    logic [7:0]          flash_cfg0;
    logic                irq_sts;
    logic                irq_msk;
    logic [31:0]         tick_cnt;
    logic [EXPIRY_W-1:0] unit_cnt;
    apb_rsp_s            rsp;
    logic                reset_req;
    logic                irq;
    logic [15:0]         vector;
  } wd_state_s;

endpackage

// ---- verification/tb_top.sv ----
/*
  Self-checking bench for the watchdog timer, driven over APB.
  Assumes the design's APB slave, a TICK_CYCLES parameter and a 10 MHz clk_sys.
*/
`timescale 1ns/1ps

module tb_top;
  // ==========================================================================
  // Signals and design instance.
  // ==========================================================================
  localparam int          TICK         = 4;
  logic                   clk_sys      = 1'b0;
  logic                   rstn         = 1'b0;
  watchdog_pkg::apb_req_s req          = '0;
  watchdog_pkg::apb_rsp_s rsp;
  logic                   wd_reset_req;
  logic                   wd_irq;
  logic                   wd_running;
  logic [15:0]            vec;
  logic [33:0]            exp_q[$];
  logic [33:0]            note;
  logic [4:0]             e;
  int                     n_errors     = 0;
  int                     n_checks     = 0;
  int                     n_rst        = 0;
  int                     n;
  int                     c;

  always #50 clk_sys = ~clk_sys;

  watchdog_timer #(.TICK_CYCLES(TICK)) uut (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .apb_req      (req),
    .apb_rsp      (rsp),
    .wd_reset_req (wd_reset_req),
    .wd_irq       (wd_irq),
    .wd_irq_vector(vec),
    .wd_running   (wd_running)
  );

  // ==========================================================================
  // Checking, closing and bus tasks.
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Each transfer leaves a note {read, error, data}; the monitor compares it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
                     input logic er);
    exp_q.push_back({~w, er, x});
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, x, 1'b0);
  endtask

  // A control bit written as one and then as zero, expiry count kept.
  task automatic seq(input logic [7:0] b);
    wr(watchdog_pkg::OFS_WD_CONTROL, {24'h00_0000, b} | e);
    wr(watchdog_pkg::OFS_WD_CONTROL, {27'h000_0000, e});
  endtask

  task automatic wait_evt(output int cyc);
    cyc = 0;
    while (wd_reset_req !== 1'b1 && wd_irq !== 1'b1 && cyc < 300) begin
      @(posedge clk_sys);
      cyc++;
    end
  endtask

  // ==========================================================================
  // Response monitor and watchdog.
  // ==========================================================================
  always @(posedge clk_sys) begin
    if (wd_reset_req === 1'b1) n_rst <= n_rst + 1;
    if (req.psel && req.penable && rsp.pready === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0_0000_0000;
      chk({31'h0, rsp.pslverr}, {31'h0, note[32]});
      if (note[33]) chk(rsp.prdata, note[31:0]);
    end
  end

  initial begin
    #(100 * 20000);
    n_errors++;
    stop_test();
  end

  // ==========================================================================
  // Tests.
  // ==========================================================================
  initial begin
    void'($urandom(90));
    e = 5'h6 + 5'($urandom % 4);
    n = (e + 1) * TICK;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk({16'h0000, vec}, 32'h0000_0063);
    rd(watchdog_pkg::OFS_POWER_MGMT, 32'h0000_0000);
    wr(watchdog_pkg::OFS_FLASH_ADDR, 32'h0000_007F);
    rd(watchdog_pkg::OFS_FLASH_DATA, 32'h0000_0008);
    apb(1'b0, 8'h1C, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    $display("test reset values done");
    seq(8'h80);
    @(negedge clk_sys);
    chk({31'h0, wd_running}, 32'h0000_0000);
    wr(watchdog_pkg::OFS_POWER_MGMT, 32'h0000_0004);
    wr(watchdog_pkg::OFS_WD_CONTROL, {24'h00_0000, 8'h80} | e);
    @(negedge clk_sys);
    chk({31'h0, wd_running}, 32'h0000_0000);
    wr(watchdog_pkg::OFS_WD_CONTROL, {27'h000_0000, e});
    @(negedge clk_sys);
    chk({31'h0, wd_running}, 32'h0000_0001);
    $display("test arm done");
    repeat (n / 2 - 4) @(posedge clk_sys);
    seq(8'h20);
    chk(n_rst, 0);
    wait_evt(c);
    chk({31'h0, c >= n - 2 && c <= n + 3}, 32'h0000_0001);
    chk({31'h0, wd_irq}, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(n_rst, 1);
    chk({31'h0, wd_running}, 32'h0000_0000);
    rd(watchdog_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    $display("test restart and reset timeout done");
    seq(8'h80);
    wr(watchdog_pkg::OFS_WD_CONTROL, {24'h00_0000, 8'h40} | e);
    @(negedge clk_sys);
    chk({31'h0, wd_running}, 32'h0000_0001);
    wr(watchdog_pkg::OFS_WD_CONTROL, {27'h000_0000, e});
    @(negedge clk_sys);
    chk({31'h0, wd_running}, 32'h0000_0000);
    rd(watchdog_pkg::OFS_WD_CONTROL, {27'h000_0000, e});
    repeat (2 * n) @(posedge clk_sys);
    chk(n_rst, 1);
    $display("test disarm done");
    wr(watchdog_pkg::OFS_FLASH_DATA, 32'h0000_0000);
    rd(watchdog_pkg::OFS_FLASH_DATA, 32'h0000_0000);
    wr(watchdog_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    seq(8'h80);
    wait_evt(c);
    chk({31'h0, c >= n - 2 && c <= n + 3}, 32'h0000_0001);
    @(negedge clk_sys);
    chk({31'h0, wd_irq}, 32'h0000_0001);
    chk(n_rst, 1);
    chk({31'h0, wd_running}, 32'h0000_0001);
    rd(watchdog_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    wr(watchdog_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, wd_irq}, 32'h0000_0000);
    wr(watchdog_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    repeat (n + 4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, wd_irq}, 32'h0000_0000);
    rd(watchdog_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    wr(watchdog_pkg::OFS_POWER_MGMT, 32'h0000_0000);
    @(negedge clk_sys);
    chk({31'h0, wd_running}, 32'h0000_0000);
    rd(watchdog_pkg::OFS_WD_CONTROL, {27'h000_0000, e});
    seq(8'h40);
    $display("test interrupt timeout done");
    stop_test();
  end
endmodule
